// [design/qebb_defs.vh]
// Constants for the erase command phase widths and read burst break sequencer.
// Assumes a plain register port; the link clock to the flash is divided down from the reference clock.
// Notes on behaviour
// R1 - Chip select high programmed cycles after erase commands
// R2 - Separate widths for address, resume, write enable
// R3 - Suspend width: single, dual, quad, reserved
// R4 - Erase instruction phase has own width
// R5 - Break only in auto, once-mode, read-then-nonread
// R6 - Size picks one byte or two
// R7 - Optionally float lines during lowest nibble of a two-byte break
// R8 - Software supplies sixteen-bit break word
// R9 - Break sent at its own width
`ifndef QEBB_DEFS_VH
`define QEBB_DEFS_VH
`define QEBB_ADDR_ERASE_MODES 32'h0c00002c
`define QEBB_ADDR_BREAK_CTRL 32'h0c000030
`define QEBB_MODES_MASK 32'h00007fff
`define QEBB_BREAK_MASK 32'h001fffff
`define QEBB_MODES_RESET 32'h00000000
`define QEBB_BREAK_RESET 32'h00000000
`define QEBB_CS_IDLE_HI 14
`define QEBB_CS_IDLE_LO 10
`define QEBB_EAD_HI 9
`define QEBB_EAD_LO 8
`define QEBB_RES_HI 7
`define QEBB_RES_LO 6
`define QEBB_SUS_HI 5
`define QEBB_SUS_LO 4
`define QEBB_WEN_HI 3
`define QEBB_WEN_LO 2
`define QEBB_ERS_HI 1
`define QEBB_ERS_LO 0
`define QEBB_HIZ_BIT 20
`define QEBB_BRKW_HI 19
`define QEBB_BRKW_LO 18
`define QEBB_SIZE_BIT 17
`define QEBB_EN_BIT 16
`define QEBB_WORD_HI 15
`define QEBB_WORD_LO 0
`define QEBB_W_SINGLE 2'h0
`define QEBB_W_DUAL 2'h1
`define QEBB_W_QUAD 2'h2
`define QEBB_CMD_NONE 3'h0
`define QEBB_CMD_WEN 3'h1
`define QEBB_CMD_ERS 3'h2
`define QEBB_CMD_SUS 3'h3
`define QEBB_CMD_RES 3'h4
`define QEBB_CMD_READ 3'h5
`define QEBB_CMD_OTHER 3'h6
`endif

// [design/qebb_sequencer.v]
// Erase phase width registers and read burst break sequencer.
// Assumes the command engine asks via cmd_req and follows chosen widths;
// the flash clock is driven by this block as a divided link clock on sck.
// Reserved width codes reach the engine as single, never as the raw code.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`include "qebb_defs.vh"
module qebb_sequencer #(
    parameter CLK_DIV = 4 // Ref cycles per half link period, 2 or more
) (
    input wire ref_clk_i, // 10 MHz clock
    input wire rst_i, // Synchronous reset, active high
    input wire [31:0] addr_i, // Register byte address
    input wire [31:0] wdata_i, // Write data
    input wire wr_i, // Write strobe
    input wire rd_i, // Read strobe
    output reg [31:0] rdata_o, // Read data, cycle after strobe
    input wire auto_mode_i, // Controller in auto mode
    input wire instruction_once_mode_i, // Instruction sent once
    input wire cmd_req_i, // Pulse: new command to start
    input wire [2:0] cmd_kind_i, // Kind of the new command
    output reg cmd_go_o, // Pulse: engine may start command
    input wire cmd_done_i, // Pulse: engine finished a command
    output reg [1:0] instr_width_o, // Instruction phase width
    output reg [1:0] addr_width_o, // Address phase width
    output reg cs_n_o, // Chip select, active low
    output reg sck_o, // Link clock to flash
    output reg [3:0] io_o, // Data lines out
    output reg [3:0] io_oe_o, // Data lines drive enable
    output reg busy_o // Sequencer owns the pins
);
    // Sequencer states
    localparam ST_IDLE = 3'h0;
    localparam ST_SHIFT = 3'h1;
    localparam ST_GAP = 3'h2;
    localparam ST_GO = 3'h3;
    localparam ST_WAIT = 3'h4;
    localparam ST_CSHI = 3'h5;
    // Register images and sequencer state
    reg [31:0] modes;
    reg [31:0] brk;
    reg [2:0] state;
    reg [2:0] prev_kind;
    reg [2:0] pend_kind;
    reg [15:0] shreg;
    reg [4:0] bits_left;
    reg [7:0] div_cnt;
    reg [4:0] idle_cnt;
    // Decoded controls
    wire [1:0] bw;
    wire [2:0] step;
    wire [4:0] total_bits;
    wire brk_need;
    wire erase_kind;
    wire [4:0] cs_idle;
    wire [3:0] lane_drive;
    wire hit_modes;
    wire hit_brk;
    wire half_done;
    wire period_done;
    // Widths for the pending command, registered below
    reg [1:0] next_instr_width;
    reg [1:0] next_addr_width;

    // Lines per clock for a width code; reserved falls back to single
    function [2:0] lanes;
        input [1:0] w;
        begin
            case (w)
                `QEBB_W_DUAL: lanes = 3'h2;
                `QEBB_W_QUAD: lanes = 3'h4;
                default: lanes = 3'h1;
            endcase
        end
    endfunction

    // Reserved code goes out as single so the engine never sees it
    function [1:0] legal_width;
        input [1:0] w;
        begin
            if (w == `QEBB_W_DUAL || w == `QEBB_W_QUAD)
                legal_width = w;
            else
                legal_width = `QEBB_W_SINGLE;
        end
    endfunction

    // Data lines driven for a width code
    function [3:0] lane_mask;
        input [1:0] w;
        begin
            case (w)
                `QEBB_W_DUAL: lane_mask = 4'h3;
                `QEBB_W_QUAD: lane_mask = 4'hf;
                default: lane_mask = 4'h1;
            endcase
        end
    endfunction

    // Bits put on the lines for one rise, top of the word first
    function [3:0] lane_data;
        input [15:0] src;
        input [1:0] w;
        begin
            case (w)
                `QEBB_W_DUAL: lane_data = {2'b00, src[15:14]};
                `QEBB_W_QUAD: lane_data = src[15:12];
                default: lane_data = {3'b000, src[15]};
            endcase
        end
    endfunction

    // R9 break width code
    assign bw = brk[`QEBB_BRKW_HI:`QEBB_BRKW_LO];
    assign step = lanes(bw);
    // R6 one or two bytes
    assign total_bits = brk[`QEBB_SIZE_BIT] ? 5'h10 : 5'h08;
    // R5 all four conditions
    assign brk_need = brk[`QEBB_EN_BIT] & auto_mode_i & instruction_once_mode_i &
                      (prev_kind == `QEBB_CMD_READ) & (cmd_kind_i != `QEBB_CMD_READ);
    // Commands that leave chip select idle afterwards
    assign erase_kind = (pend_kind == `QEBB_CMD_WEN) | (pend_kind == `QEBB_CMD_ERS) |
                        (pend_kind == `QEBB_CMD_SUS) | (pend_kind == `QEBB_CMD_RES);
    assign cs_idle = modes[`QEBB_CS_IDLE_HI:`QEBB_CS_IDLE_LO];
    // R9 lines driven at break width
    assign lane_drive = lane_mask(bw);
    // Address decode shared by writes and reads
    assign hit_modes = (addr_i == `QEBB_ADDR_ERASE_MODES);
    assign hit_brk = (addr_i == `QEBB_ADDR_BREAK_CTRL);
    // Ends of a half and of a whole link period
    assign half_done = (div_cnt == CLK_DIV[7:0] - 8'h01);
    assign period_done = (div_cnt == CLK_DIV[7:0] * 8'h02 - 8'h01);

    // Register writes and reads, unmapped reads as zero
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            modes <= `QEBB_MODES_RESET;
            brk <= `QEBB_BREAK_RESET;
            rdata_o <= 32'h00000000;
        end else begin
            if (wr_i && hit_modes)
                modes <= wdata_i & `QEBB_MODES_MASK;
            // R8 break word stored
            if (wr_i && hit_brk)
                brk <= wdata_i & `QEBB_BREAK_MASK;
            // Read data stands one cycle, zero otherwise
            if (rd_i && hit_modes)
                rdata_o <= modes;
            else if (rd_i && hit_brk)
                rdata_o <= brk;
            else
                rdata_o <= 32'h00000000;
        end
    end

    // Phase widths chosen for the pending command
    always @* begin
        next_instr_width = `QEBB_W_SINGLE;
        next_addr_width = `QEBB_W_SINGLE;
        case (pend_kind)
            // R2 write enable width
            `QEBB_CMD_WEN: next_instr_width = legal_width(modes[`QEBB_WEN_HI:`QEBB_WEN_LO]);
            // R4 erase instruction width
            `QEBB_CMD_ERS: begin
                next_instr_width = legal_width(modes[`QEBB_ERS_HI:`QEBB_ERS_LO]);
                // R2 erase address width
                next_addr_width = legal_width(modes[`QEBB_EAD_HI:`QEBB_EAD_LO]);
            end
            // R3 suspend width
            `QEBB_CMD_SUS: next_instr_width = legal_width(modes[`QEBB_SUS_HI:`QEBB_SUS_LO]);
            // R2 resume width
            `QEBB_CMD_RES: next_instr_width = legal_width(modes[`QEBB_RES_HI:`QEBB_RES_LO]);
            default: next_instr_width = `QEBB_W_SINGLE;
        endcase
    end

    // Widths registered so the engine sees flip-flop outputs
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            instr_width_o <= `QEBB_W_SINGLE;
            addr_width_o <= `QEBB_W_SINGLE;
        end else begin
            instr_width_o <= next_instr_width;
            addr_width_o <= next_addr_width;
        end
    end

    // Main sequencer: break shift, command hand-off, chip select idle
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            // Pins released, select high
            state <= ST_IDLE;
            prev_kind <= `QEBB_CMD_NONE;
            pend_kind <= `QEBB_CMD_NONE;
            shreg <= 16'h0000;
            bits_left <= 5'h00;
            div_cnt <= 8'h00;
            idle_cnt <= 5'h00;
            cmd_go_o <= 1'b0;
            cs_n_o <= 1'b1;
            sck_o <= 1'b0;
            io_o <= 4'h0;
            io_oe_o <= 4'h0;
            busy_o <= 1'b0;
        end else begin
            cmd_go_o <= 1'b0;
            case (state)
                // Wait for a request; a due break goes first
                ST_IDLE: begin
                    if (cmd_req_i) begin
                        pend_kind <= cmd_kind_i;
                        busy_o <= 1'b1;
                        if (brk_need) begin
                            // R8 load word, top byte first
                            shreg <= brk[`QEBB_WORD_HI:`QEBB_WORD_LO];
                            bits_left <= total_bits;
                            cs_n_o <= 1'b0;
                            div_cnt <= 8'h00;
                            state <= ST_SHIFT;
                        end else begin
                            state <= ST_GO;
                        end
                    end
                end
                ST_SHIFT: begin
                    // Data set up on low phase, flash samples rising sck
                    if (div_cnt == 8'h00 && !sck_o) begin
                        if (bits_left == 5'h00) begin
                            cs_n_o <= 1'b1;
                            io_oe_o <= 4'h0;
                            state <= ST_GAP;
                        end else begin
                            io_o <= lane_data(shreg, bw);
                            // R7 float lines on lowest nibble, two-byte size only
                            if (brk[`QEBB_HIZ_BIT] && brk[`QEBB_SIZE_BIT] && bits_left <= 5'h04)
                                io_oe_o <= 4'h0;
                            else
                                io_oe_o <= lane_drive;
                            // R9 shift by lane count
                            shreg <= shreg << step;
                        end
                    end
                    // Bits counted on the rise, so the last chunk still gets its edge
                    if (half_done) begin
                        div_cnt <= 8'h00;
                        if (sck_o) begin
                            sck_o <= 1'b0;
                        end else if (bits_left != 5'h00) begin
                            sck_o <= 1'b1;
                            bits_left <= bits_left - {2'b00, step};
                        end
                    end else begin
                        div_cnt <= div_cnt + 8'h01;
                    end
                end
                // Frame over, hand the pins back
                ST_GAP: begin
                    sck_o <= 1'b0;
                    prev_kind <= `QEBB_CMD_OTHER;
                    state <= ST_GO;
                end
                // One-cycle go to the engine
                ST_GO: begin
                    cmd_go_o <= 1'b1;
                    busy_o <= 1'b0;
                    state <= ST_WAIT;
                end
                // Engine owns the pins until done
                ST_WAIT: begin
                    if (cmd_done_i) begin
                        prev_kind <= pend_kind;
                        idle_cnt <= 5'h00;
                        // Fresh period count, not what the break left behind
                        div_cnt <= 8'h00;
                        if (erase_kind) begin
                            busy_o <= 1'b1;
                            state <= ST_CSHI;
                        end else begin
                            busy_o <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_CSHI: begin
                    // R1 hold chip select high, counted in link clocks
                    cs_n_o <= 1'b1;
                    if (idle_cnt >= cs_idle) begin
                        busy_o <= 1'b0;
                        state <= ST_IDLE;
                    end else if (period_done) begin
                        div_cnt <= 8'h00;
                        idle_cnt <= idle_cnt + 5'h01;
                    end else begin
                        div_cnt <= div_cnt + 8'h01;
                    end
                end
                // Unused codes recover to idle
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // qebb_sequencer

// [verification/qebb_checker_asserts.sv]
// Checker on the sequencer ports.
// Bound to every sequencer instance; sees only its pins.
`timescale 1ns/100ps
module qebb_checker (
    input wire ref_clk_i, // Clock
    input wire rst_i, // Reset
    input wire rd_i, // Read strobe
    input wire [31:0] rdata_o, // Read data
    input wire cmd_req_i, // Request
    input wire auto_mode_i, // Auto mode
    input wire cmd_go_o, // Go pulse
    input wire [1:0] instr_width_o, // Width
    input wire [1:0] addr_width_o, // Address width
    input wire cs_n_o, // Chip select
    input wire sck_o, // Link clock
    input wire [3:0] io_oe_o, // Drive enable
    input wire busy_o // Busy
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Read data only in the cycle after a read
    property p_rd_idle;
        !$past(rd_i) |-> rdata_o == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data off cycle");
    property p_go_pulse;
        cmd_go_o |=> !cmd_go_o;
    endproperty
    a_go_pulse: assert property (p_go_pulse) else $error("go too long");
    // Without auto mode no break may delay the go
    property p_go_fast;
        cmd_req_i && !busy_o && !auto_mode_i |-> ##2 cmd_go_o;
    endproperty
    a_go_fast: assert property (p_go_fast) else $error("go late");
    property p_go_width;
        cmd_go_o |=> $stable(instr_width_o);
    endproperty
    a_go_width: assert property (p_go_width) else $error("width moved");
    // Reserved width code never reaches the engine
    property p_width_legal;
        instr_width_o != 2'h3 && addr_width_o != 2'h3;
    endproperty
    a_width_legal: assert property (p_width_legal) else $error("reserved width out");
    property p_cs_busy;
        !cs_n_o |-> busy_o;
    endproperty
    a_cs_busy: assert property (p_cs_busy) else $error("select without busy");
    property p_oe_cs;
        io_oe_o != 4'h0 |-> !cs_n_o;
    endproperty
    a_oe_cs: assert property (p_oe_cs) else $error("drive outside frame");
    property p_idle_pins;
        !busy_o |-> cs_n_o && io_oe_o == 4'h0;
    endproperty
    a_idle_pins: assert property (p_idle_pins) else $error("pins held when idle");
    property p_sck_frame;
        $changed(sck_o) |-> !cs_n_o || !$past(cs_n_o);
    endproperty
    a_sck_frame: assert property (p_sck_frame) else $error("clock outside frame");
endmodule // qebb_checker

bind qebb_sequencer qebb_checker u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .cmd_req_i(cmd_req_i), .auto_mode_i(auto_mode_i), .cmd_go_o(cmd_go_o),
    .instr_width_o(instr_width_o), .addr_width_o(addr_width_o), .cs_n_o(cs_n_o),
    .sck_o(sck_o), .io_oe_o(io_oe_o),
    .busy_o(busy_o));

// [verification/qebb_flash_model.sv]
// Flash side model: captures the break frame on link clock rises.
// Bench tells it the lane code the controller is set to.
`timescale 1ns/100ps
module qebb_flash_model (
    input wire cs_n_i, // Chip select
    input wire sck_i, // Link clock
    input wire [3:0] io_i, // Lines from controller
    input wire [3:0] oe_i, // Their drive enables
    input wire [1:0] width_i, // Lane code
    output reg [15:0] word_o, // Bits shifted in
    output integer bits_o, // Bits in frame
    output integer hiz_o, // Bits with lines floating
    output integer frames_o // Frames seen
);
    integer n;
    reg [3:0] m;
    initial frames_o = 0;
    // New frame clears the capture
    always @(negedge cs_n_i) begin
        frames_o = frames_o + 1;
        bits_o = 0;
        hiz_o = 0;
        word_o = 16'h0;
    end
    always @(posedge sck_i) if (!cs_n_i) begin
        n = (width_i == 2'h2) ? 4 : (width_i == 2'h1) ? 2 : 1; // Reserved code as single
        m = (4'h1 << n) - 4'h1;
        word_o = (word_o << n) | {12'h0, io_i & oe_i & m}; // Floating lines read as 0
        bits_o = bits_o + n;
        if (oe_i == 4'h0)
            hiz_o = hiz_o + n;
    end
endmodule // qebb_flash_model

// [verification/qspi_erase_cmd_burst_break_tb_top.sv]
// Bench for the erase width and break sequencer.
// Drives register port and command handshake; flash model watches the pins.
`timescale 1ns/100ps
`include "qebb_defs.vh"
module qspi_erase_cmd_burst_break_tb_top;
    localparam DIV = 4; // 800 ns link period at 100 ns clock
    reg ref_clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg [31:0] addr_i = 32'h0;
    reg [31:0] wdata_i = 32'h0;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg auto_mode_i = 1'b0;
    reg instruction_once_mode_i = 1'b0;
    reg cmd_req_i = 1'b0;
    reg [2:0] cmd_kind_i = 3'h0;
    reg cmd_done_i = 1'b0;
    reg [1:0] bw = 2'h0;
    wire [31:0] rdata_o;
    wire cmd_go_o, cs_n_o, sck_o, busy_o;
    wire [1:0] instr_width_o, addr_width_o;
    wire [3:0] io_o, io_oe_o;
    wire [15:0] word;
    integer bits, hiz, frames, i, k, f0;
    integer fail_count = 0;
    integer samples_checked = 0;
    qebb_sequencer #(.CLK_DIV(DIV)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .auto_mode_i(auto_mode_i),
        .instruction_once_mode_i(instruction_once_mode_i), .cmd_req_i(cmd_req_i),
        .cmd_kind_i(cmd_kind_i), .cmd_go_o(cmd_go_o), .cmd_done_i(cmd_done_i),
        .instr_width_o(instr_width_o), .addr_width_o(addr_width_o), .cs_n_o(cs_n_o),
        .sck_o(sck_o), .io_o(io_o), .io_oe_o(io_oe_o), .busy_o(busy_o));
    qebb_flash_model flash (.cs_n_i(cs_n_o), .sck_i(sck_o), .io_i(io_o), .oe_i(io_oe_o),
        .width_i(bw), .word_o(word), .bits_o(bits), .hiz_o(hiz), .frames_o(frames));
    always #50 ref_clk_i = ~ref_clk_i;
    function [1:0] ew(input [1:0] c);
        ew = (c == 2'h3) ? 2'h0 : c; // Reserved code falls back to single
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("ERROR %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [31:0] a, input [31:0] d);
        begin
            @(posedge ref_clk_i);
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            @(posedge ref_clk_i);
            wr_i <= 1'b0;
        end
    endtask
    task rd(input [31:0] a, input [31:0] e);
        begin
            @(posedge ref_clk_i);
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge ref_clk_i);
            rd_i <= 1'b0;
            @(posedge ref_clk_i);
            chk(rdata_o, e);
        end
    endtask
    // One command: request, wait for go, finish, then time the select idle
    task cmd(input [2:0] kd, input [1:0] ew_i, input [1:0] ea, input integer idle);
        integer n;
        begin
            @(posedge ref_clk_i);
            cmd_req_i <= 1'b1;
            cmd_kind_i <= kd;
            @(posedge ref_clk_i);
            cmd_req_i <= 1'b0;
            n = 0;
            while (cmd_go_o !== 1'b1 && n < 400) begin
                @(posedge ref_clk_i);
                n = n + 1;
            end
            chk({31'h0, cmd_go_o}, 32'h1);
            if (kd < `QEBB_CMD_READ)
                chk({30'h0, instr_width_o}, {30'h0, ew_i});
            if (kd == `QEBB_CMD_ERS)
                chk({30'h0, addr_width_o}, {30'h0, ea});
            cmd_done_i <= 1'b1;
            @(posedge ref_clk_i);
            cmd_done_i <= 1'b0;
            @(posedge ref_clk_i);
            n = 0;
            while (busy_o === 1'b1 && n < 400) begin
                @(posedge ref_clk_i);
                n = n + 1;
            end
            if (idle > 0)
                chk({31'h0, n >= idle && n < idle + 6}, 32'h1);
        end
    endtask
    task final_report;
        begin
            $display("checks %0d errors %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        #1000000;
        fail_count = fail_count + 1;
        final_report;
    end
    initial begin
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(`QEBB_ADDR_ERASE_MODES, 32'h0);
        rd(`QEBB_ADDR_BREAK_CTRL, 32'h0);
        wr(`QEBB_ADDR_ERASE_MODES, 32'hffffffff);
        rd(`QEBB_ADDR_ERASE_MODES, 32'h00007fff);
        wr(`QEBB_ADDR_BREAK_CTRL, 32'hffffffff);
        rd(`QEBB_ADDR_BREAK_CTRL, 32'h001fffff);
        wr(32'h0c000034, 32'hffffffff);
        rd(32'h0c000034, 32'h0);
        wr(`QEBB_ADDR_BREAK_CTRL, 32'h0);
        // Every width code in every field, select idle of two link periods
        for (i = 0; i < 4; i = i + 1) begin
            wr(`QEBB_ADDR_ERASE_MODES,
               {17'h0, 5'h2, 2'(i), 2'(i+1), 2'(i+2), 2'(i+3), 2'(i+2)});
            cmd(`QEBB_CMD_WEN, ew(2'(i+3)), 2'h0, 4*DIV);
            cmd(`QEBB_CMD_ERS, ew(2'(i+2)), ew(2'(i)), 4*DIV);
            cmd(`QEBB_CMD_SUS, ew(2'(i+2)), 2'h0, 4*DIV);
            cmd(`QEBB_CMD_RES, ew(2'(i+1)), 2'h0, 4*DIV);
        end
        // Break after a read, every lane code and both sizes
        auto_mode_i <= 1'b1;
        instruction_once_mode_i <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            k = (i == 1 || i == 2);
            bw <= 2'(i);
            wr(`QEBB_ADDR_BREAK_CTRL, {11'h0, i == 2, 2'(i), k[0], 1'b1, 16'ha5c3});
            cmd(`QEBB_CMD_READ, 2'h0, 2'h0, 0);
            cmd(`QEBB_CMD_OTHER, 2'h0, 2'h0, 0);
            chk(bits, k ? 16 : 8);
            chk({16'h0, word}, k ? (i == 2 ? 32'ha5c0 : 32'ha5c3) : 32'h00a5);
            chk(hiz, i == 2 ? 4 : 0);
        end
        // No break when any condition is missing, enable last
        for (i = 0; i < 4; i = i + 1) begin
            auto_mode_i <= (i != 0);
            instruction_once_mode_i <= (i != 1);
            if (i == 3)
                wr(`QEBB_ADDR_BREAK_CTRL, 32'h00000000);
            f0 = frames;
            cmd(`QEBB_CMD_READ, 2'h0, 2'h0, 0);
            cmd((i == 2) ? `QEBB_CMD_READ : `QEBB_CMD_OTHER, 2'h0, 2'h0, 0);
            chk(frames, f0);
        end
        final_report;
    end
endmodule // qspi_erase_cmd_burst_break_tb_top
